// [hebtc_regs.sv]
// Hardware event bank select and trigger control over AXI4-Lite
// Contract
// - Bank index zero maps event and trigger enables to events 0-31.
// - Index one maps events 32-63; each further index the next 32.
// - With 32 or fewer events, bank select ignores writes, reads zero.
// - Bank index width just covers the implemented event count.
// - Every bank index bit resets to zero.
// - Control bit 7 lets monitored triggers go out with ATID 0x7D.
// - Bit 7 exists only for trace bus type 0b0001.
// - Control bit 4: zero multi-shot, one single-shot.
// - Bit 4 exists only with trigger capability 0b10.
// - In single-shot mode bit 5 reads one once the trigger occurred.
// - In multi-shot mode bit 5 is undefined.
// - Writing one to bit 6 in single-shot mode clears bit 5.
// - Bit 0 enables tracing, resets zero, needs global enable too.
// - Trigger enable holds one bit per event of the selected bank.
`timescale 1ns/100ps
`include "hebtc_defs.svh"
module hebtc_regs
  import hebtc_pkg::*;
#(
  parameter int         NUM_EVENTS     = 256,
  parameter logic [3:0] TRACE_BUS_TYPE = `HEBTC_BUS_TYPE_ATB,
  parameter logic [1:0] TRIG_CAP       = `HEBTC_TRIG_CAP_SHOT
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [`HEBTC_ADDR_W-1:0] awaddr_i,
  input  wire logic                     awvalid_i,
  output logic                          awready_o,
  input  wire hebtc_word_t              wdata_i,
  input  wire logic [3:0]               wstrb_i,
  input  wire logic                     wvalid_i,
  output logic                          wready_o,
  output hebtc_resp_e                   bresp_o,
  output logic                          bvalid_o,
  input  wire logic                     bready_i,
  input  wire logic [`HEBTC_ADDR_W-1:0] araddr_i,
  input  wire logic                     arvalid_i,
  output logic                          arready_o,
  output hebtc_word_t                   rdata_o,
  output hebtc_resp_e                   rresp_o,
  output logic                          rvalid_o,
  input  wire logic                     rready_i,
  input  wire logic                     global_trace_en_i,
  input  wire logic [NUM_EVENTS-1:0]    hw_event_i,
  output logic [NUM_EVENTS-1:0]         event_trace_o,
  output logic                          trigger_o,
  output logic                          bus_trigger_o,
  output logic [6:0]                    trigger_atid_o
);
  localparam int BANKS = NUM_EVENTS / `HEBTC_BANK_EVENTS;
  localparam int BANK_W = (BANKS > 1) ? $clog2(BANKS) : 1;
  localparam bit HAS_BANKS = (BANKS > 1);
  localparam bit HAS_BUS_TRIG = (TRACE_BUS_TYPE == `HEBTC_BUS_TYPE_ATB);
  localparam bit HAS_SHOT = (TRIG_CAP == `HEBTC_TRIG_CAP_SHOT);

  // Non power-of-two bank counts would leave unbacked index codes
  if (NUM_EVENTS < `HEBTC_BANK_EVENTS || NUM_EVENTS > 256 ||
      NUM_EVENTS % `HEBTC_BANK_EVENTS != 0 ||
      (BANKS & (BANKS - 1)) != 0) begin : g_bad_events
    $error("NUM_EVENTS must be 32, 64, 128 or 256");
  end

  // Write channel holding registers
  logic                     aw_held;
  logic                     w_held;
  logic [`HEBTC_ADDR_W-1:0] aw_addr;
  hebtc_word_t              w_data;
  logic [3:0]               w_strb;

  // Control state
  logic [BANK_W-1:0] bank;
  logic              trace_en;
  logic              shot_sel;
  logic              bus_trig_en;
  logic              occurred;
  logic              trig_pulse;

  // Write decode
  wire do_write = aw_held && w_held && !bvalid_o;
  wire [`HEBTC_ADDR_W-1:0] wa = {aw_addr[`HEBTC_ADDR_W-1:2], 2'b00};
  wire sel_w_evt  = (wa == `HEBTC_OFF_EVT_EN);
  wire sel_w_trig = (wa == `HEBTC_OFF_TRIG_EN);
  wire sel_w_bank = (wa == `HEBTC_OFF_BANK_SEL);
  wire sel_w_mcr  = (wa == `HEBTC_OFF_MAIN_CTL);
  wire w_mapped   = sel_w_evt || sel_w_trig || sel_w_bank || sel_w_mcr;
  wire wr_evt     = do_write && sel_w_evt;
  wire wr_trig    = do_write && sel_w_trig;
  wire wr_bank    = do_write && sel_w_bank && w_strb[0] && HAS_BANKS;
  wire wr_mcr     = do_write && sel_w_mcr && w_strb[0];
  // Clear acts only while single-shot is selected
  wire clear_req  = wr_mcr && w_data[`HEBTC_BIT_CLEAR] && shot_sel;

  // Read decode
  wire ar_take = arvalid_i && arready_o;
  wire [`HEBTC_ADDR_W-1:0] ra = {araddr_i[`HEBTC_ADDR_W-1:2], 2'b00};
  wire sel_r_evt  = (ra == `HEBTC_OFF_EVT_EN);
  wire sel_r_trig = (ra == `HEBTC_OFF_TRIG_EN);
  wire sel_r_bank = (ra == `HEBTC_OFF_BANK_SEL);
  wire sel_r_mcr  = (ra == `HEBTC_OFF_MAIN_CTL);
  wire r_mapped   = sel_r_evt || sel_r_trig || sel_r_bank || sel_r_mcr;

  hebtc_word_t evt_rd;
  hebtc_word_t trig_rd;
  logic [NUM_EVENTS-1:0] evt_all;
  logic [NUM_EVENTS-1:0] trig_all;

  wire hebtc_word_t bank_rd = HAS_BANKS ? 32'(bank) : 32'h0000_0000;
  // Clear bit is write-only and reads as zero
  // status read back
  wire hebtc_word_t mcr_rd = {24'h00_0000,
                              bus_trig_en, 1'b0, occurred, shot_sel,
                              3'b000, trace_en};
  wire hebtc_word_t rd_mux = sel_r_evt  ? evt_rd  :
                             sel_r_trig ? trig_rd :
                             sel_r_bank ? bank_rd :
                             sel_r_mcr  ? mcr_rd  : 32'h0000_0000;

  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o  = !w_held && !bvalid_o;
  assign arready_o = !rvalid_o;

  // Address and data may arrive in either order
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid_i && awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr_i;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid_i && wready_o) begin
      w_held <= 1'b1;
      w_data <= wdata_i;
      w_strb <= wstrb_i;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= HEBTC_OKAY;
    end else if (do_write) begin
      bvalid_o <= 1'b1;
      bresp_o  <= w_mapped ? HEBTC_OKAY : HEBTC_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= HEBTC_OKAY;
    end else if (ar_take) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_mux;
      rresp_o  <= r_mapped ? HEBTC_OKAY : HEBTC_SLVERR;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bank <= {BANK_W{`HEBTC_RST_BANK}};
    else if (wr_bank) bank <= w_data[BANK_W-1:0];
  end

  // Unknown-reset bits are cleared anyway to avoid X on triggers
  // bus trigger bit gated by type
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trace_en    <= `HEBTC_RST_TRACE_EN;
      shot_sel    <= `HEBTC_RST_SHOT;
      bus_trig_en <= `HEBTC_RST_BUS_TRIG;
    end else if (wr_mcr) begin
      trace_en    <= w_data[`HEBTC_BIT_TRACE_EN];
      shot_sel    <= HAS_SHOT && w_data[`HEBTC_BIT_SHOT_SEL];
      bus_trig_en <= HAS_BUS_TRIG && w_data[`HEBTC_BIT_BUS_TRIG];
    end
  end

  hebtc_bank #(
    .BANKS  (BANKS),
    .BANK_W (BANK_W)
  ) u_evt_bank (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_evt),
    .sel_i   (bank),
    .wdata_i (w_data),
    .wstrb_i (w_strb),
    .rdata_o (evt_rd),
    .flat_o  (evt_all)
  );

  hebtc_bank #(
    .BANKS  (BANKS),
    .BANK_W (BANK_W)
  ) u_trig_bank (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_trig),
    .sel_i   (bank),
    .wdata_i (w_data),
    .wstrb_i (w_strb),
    .rdata_o (trig_rd),
    .flat_o  (trig_all)
  );

  wire trace_active = trace_en && global_trace_en_i;
  wire trig_hit = trace_active && |(hw_event_i & trig_all);

  hebtc_trig u_trig (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .single_i   (shot_sel),
    .clear_i    (clear_req),
    .hit_i      (trig_hit),
    .trigger_o  (trig_pulse),
    .occurred_o (occurred)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) event_trace_o <= '0;
    else event_trace_o <= trace_active ? (hw_event_i & evt_all) : '0;
  end

  assign trigger_o = trig_pulse;
  assign bus_trigger_o  = trig_pulse && bus_trig_en;
  assign trigger_atid_o = `HEBTC_TRIG_ATID;

  sequence s_bank_write;
    wr_bank;
  endsequence

  sequence s_bank_seen(logic [BANK_W-1:0] v);
    ##1 (bank == v);
  endsequence

  property p_bank_update;
    @(posedge clk_i) disable iff (rst_i)
    s_bank_write |-> s_bank_seen(w_data[BANK_W-1:0]);
  endproperty
  a_bank_update: assert property (p_bank_update)
    else $error("Bank index not taken from write");

  property p_bank_zero;
    @(posedge clk_i) disable iff (rst_i)
    ar_take && sel_r_bank && !HAS_BANKS |=> rdata_o == 32'h0000_0000;
  endproperty
  a_bank_zero: assert property (p_bank_zero)
    else $error("Bank select read nonzero without banks");

  property p_evt_read;
    @(posedge clk_i) disable iff (rst_i)
    ar_take && sel_r_evt |=>
      rdata_o == evt_all[$past(bank)*`HEBTC_BANK_EVENTS +: 32];
  endproperty
  a_evt_read: assert property (p_evt_read)
    else $error("Event enable read not from selected bank");

  property p_trace_gate;
    @(posedge clk_i) disable iff (rst_i)
    !(trace_en && global_trace_en_i) |=> event_trace_o == '0;
  endproperty
  a_trace_gate: assert property (p_trace_gate)
    else $error("Event traced while tracing disabled");

  property p_trig_cause;
    @(posedge clk_i) disable iff (rst_i)
    trig_pulse |-> $past(trace_active) &&
                   $past(|(hw_event_i & trig_all));
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("Trigger without enabled event");

  property p_bus_trig;
    @(posedge clk_i) disable iff (rst_i)
    bus_trigger_o |-> trig_pulse && bus_trig_en &&
                      trigger_atid_o == `HEBTC_TRIG_ATID;
  endproperty
  a_bus_trig: assert property (p_bus_trig)
    else $error("Bus trigger without enable");

  property p_bus_absent;
    @(posedge clk_i) disable iff (rst_i)
    !HAS_BUS_TRIG |-> !bus_trig_en;
  endproperty
  a_bus_absent: assert property (p_bus_absent)
    else $error("Bus trigger bit set while absent");

  property p_shot_absent;
    @(posedge clk_i) disable iff (rst_i)
    !HAS_SHOT |-> !shot_sel;
  endproperty
  a_shot_absent: assert property (p_shot_absent)
    else $error("Mode bit set while absent");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    clear_req && !trig_hit |=> !occurred;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Trigger status not cleared");

  property p_mode_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_mcr |=> shot_sel == (HAS_SHOT && $past(w_data[4]));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("Mode bit not written");

  property p_write_resp;
    @(posedge clk_i) disable iff (rst_i)
    do_write |=> bvalid_o ##0 (bresp_o == (w_mapped ? HEBTC_OKAY :
                                                      HEBTC_SLVERR)) [*1];
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response missing");
endmodule : hebtc_regs

// [hebtc_defs.svh]
// Offsets, field positions and reset values of the event bank block
`ifndef HEBTC_DEFS_SVH
`define HEBTC_DEFS_SVH
`define HEBTC_ADDR_W        8
`define HEBTC_OFF_EVT_EN    8'h00
`define HEBTC_OFF_TRIG_EN   8'h20
`define HEBTC_OFF_BANK_SEL  8'h60
`define HEBTC_OFF_MAIN_CTL  8'h64
`define HEBTC_BIT_TRACE_EN  0
`define HEBTC_BIT_SHOT_SEL  4
`define HEBTC_BIT_OCCURRED  5
`define HEBTC_BIT_CLEAR     6
`define HEBTC_BIT_BUS_TRIG  7
`define HEBTC_RST_TRACE_EN  1'b0
`define HEBTC_RST_BANK      1'b0
`define HEBTC_RST_SHOT      1'b0
`define HEBTC_RST_BUS_TRIG  1'b0
`define HEBTC_RST_OCCURRED  1'b0
`define HEBTC_RST_ENABLES   32'h0000_0000
`define HEBTC_BANK_EVENTS   32
`define HEBTC_TRIG_ATID     7'h7D
`define HEBTC_BUS_TYPE_ATB  4'h1
`define HEBTC_TRIG_CAP_SHOT 2'h2
`endif

// [hebtc_pkg.sv]
// Types shared by the event bank block
package hebtc_pkg;
  typedef enum logic [1:0] {
    HEBTC_OKAY   = 2'h0,
    HEBTC_SLVERR = 2'h2
  } hebtc_resp_e;
  typedef logic [31:0] hebtc_word_t;
endpackage : hebtc_pkg

// [hebtc_bank.sv]
// Banked 32-bit enable store, one word per bank
`timescale 1ns/100ps
`include "hebtc_defs.svh"
module hebtc_bank
  import hebtc_pkg::*;
#(
  parameter int BANKS  = 8,
  parameter int BANK_W = 3
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wr_i,
  input  wire logic [BANK_W-1:0]             sel_i,
  input  wire hebtc_word_t                   wdata_i,
  input  wire logic [3:0]                    wstrb_i,
  output hebtc_word_t                        rdata_o,
  output logic [BANKS*`HEBTC_BANK_EVENTS-1:0] flat_o
);
  hebtc_word_t mem [BANKS];

  assign rdata_o = mem[sel_i];

  // Only the selected bank's byte lanes change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int b = 0; b < BANKS; b++) mem[b] <= `HEBTC_RST_ENABLES;
    end else if (wr_i) begin
      for (int l = 0; l < 4; l++)
        if (wstrb_i[l]) mem[sel_i][l*8 +: 8] <= wdata_i[l*8 +: 8];
    end
  end

  always_comb begin
    for (int b = 0; b < BANKS; b++)
      flat_o[b*`HEBTC_BANK_EVENTS +: `HEBTC_BANK_EVENTS] = mem[b];
  end
endmodule : hebtc_bank

// [hebtc_trig.sv]
// Single-shot and multi-shot trigger control
`timescale 1ns/100ps
`include "hebtc_defs.svh"
module hebtc_trig (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic single_i,
  input  wire logic clear_i,
  input  wire logic hit_i,
  output logic      trigger_o,
  output logic      occurred_o
);
  logic fire;
  logic next_occurred;

  assign fire = hit_i && !(single_i && occurred_o);

  always_comb begin
    next_occurred = occurred_o;
    if (!single_i) next_occurred = 1'b0;
    else if (fire) next_occurred = 1'b1;
    else if (clear_i) next_occurred = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      occurred_o <= `HEBTC_RST_OCCURRED;
      trigger_o  <= 1'b0;
    end else begin
      occurred_o <= next_occurred;
      trigger_o  <= fire;
    end
  end

  property p_shot_blocks;
    @(posedge clk_i) disable iff (rst_i)
    single_i && occurred_o |=> !trigger_o;
  endproperty
  a_shot_blocks: assert property (p_shot_blocks)
    else $error("Trigger fired after single shot");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    single_i && hit_i && !occurred_o |=> occurred_o && trigger_o;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("First single-shot trigger not recorded");
endmodule : hebtc_trig

// [hebtc_evt_src.sv]
// Behavioural model of the hardware event sources
`timescale 1ns/100ps
module hebtc_evt_src #(
  parameter int N = 64
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         go_i,
  input  wire logic [5:0]   idx_i,
  input  wire logic [3:0]   len_i,
  output logic [N-1:0]      hw_event_o
);
  logic [3:0] left;
  logic [5:0] cur;
  // Plain level sources: an idle line sits low
  assign hw_event_o = (left != 4'h0) ? (N'(1) << cur) : '0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left <= 4'h0;
      cur  <= 6'h00;
    end else if (go_i) begin
      left <= len_i;
      cur  <= idx_i;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
endmodule : hebtc_evt_src

// [tb_top.sv]
// Self-checking bench for the event bank and trigger control
`timescale 1ns/100ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module tb_top
  import hebtc_pkg::*;
;
  logic        clk_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
  logic        rready_i, global_trace_en_i, awready_o, wready_o, bvalid_o;
  logic        arready_o, rvalid_o, trigger_o, bus_trigger_o, go;
  logic [7:0]  awaddr_i, araddr_i;
  logic [3:0]  wstrb_i, len;
  logic [5:0]  idx;
  logic [6:0]  trigger_atid_o;
  logic [63:0] hw_event_i, event_trace_o, trace_acc, ek, ej;
  hebtc_word_t wdata_i, rdata_o, rdata_s, rd, rd2, ee0, ee1, te0, te1;
  hebtc_resp_e bresp_o, rresp_o, rs;
  int          num_errors, checked, ntrig, nbus, j, k;

  hebtc_regs #(.NUM_EVENTS(64)) i_hebtc_regs (.*);
  // Small part: no banks, and no bus trigger bit
  hebtc_regs #(.NUM_EVENTS(32), .TRACE_BUS_TYPE(4'h0)) i_hebtc_regs_small (.*,
    .awready_o(), .wready_o(), .bresp_o(), .bvalid_o(), .arready_o(),
    .rdata_o(rdata_s), .rresp_o(), .rvalid_o(), .event_trace_o(),
    .hw_event_i(hw_event_i[31:0]), .trigger_o(), .bus_trigger_o(),
    .trigger_atid_o());
  hebtc_evt_src #(.N(64)) i_hebtc_evt_src (.clk_i(clk_i), .rst_i(rst_i),
    .go_i(go), .idx_i(idx), .len_i(len), .hw_event_o(hw_event_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Count on the falling edge, clear of the launching edge
  always @(negedge clk_i) begin
    ntrig += int'(trigger_o);
    nbus += int'(bus_trigger_o);
    trace_acc = trace_acc | event_trace_o;
  end

  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // One write or one read; handshakes judged before the taking edge
  task automatic acc(input bit w, input logic [7:0] a, input hebtc_word_t d);
    bit ta, tw, tr, done;
    done = 1'b0;
    @(posedge clk_i);
    if (w) begin
      awaddr_i <= a; wdata_i <= d; awvalid_i <= 1'b1; wvalid_i <= 1'b1;
      bready_i <= 1'b1;
    end else begin
      araddr_i <= a; arvalid_i <= 1'b1; rready_i <= 1'b1;
    end
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_i);
      ta = w ? awvalid_i && awready_o : arvalid_i && arready_o;
      tw = wvalid_i && wready_o;
      tr = w ? bvalid_o : rvalid_o;
      rd = rdata_o; rd2 = rdata_s; rs = w ? bresp_o : rresp_o;
      @(posedge clk_i);
      if (ta && w) awvalid_i <= 1'b0;
      if (ta && !w) arvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
      if (tr) begin
        bready_i <= 1'b0; rready_i <= 1'b0; done = 1'b1;
      end
    end
    if (!done) begin
      num_errors++;
      stop_test();
    end
  endtask : acc

  task automatic rchk(input logic [7:0] a, input hebtc_word_t e);
    acc(1'b0, a, '0);
    `CHK(rd, e);
    `CHK(rs, HEBTC_OKAY);
  endtask : rchk

  // One-cycle event, then compare trace and trigger counts
  task automatic pulse(input int i, input logic [63:0] et, input int nt, nb);
    int t0, b0;
    trace_acc = '0; t0 = ntrig; b0 = nbus;
    @(posedge clk_i);
    go <= 1'b1; idx <= 6'(i); len <= 4'h1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK(trace_acc, et);
    `CHK(ntrig - t0, nt);
    `CHK(nbus - b0, nb);
  endtask : pulse

  function automatic logic [63:0] ev_bit(input int i);
    return 64'h1 << i;
  endfunction : ev_bit

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h1A21));
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {go, global_trace_en_i, ntrig, nbus, num_errors, checked} = '0;
    awaddr_i = '0; araddr_i = '0; wdata_i = '0; wstrb_i = 4'hF;
    idx = '0; len = '0; trace_acc = '0; rst_i = 1'b1;
    j = $urandom_range(31, 0); k = $urandom_range(63, 32);
    ee0 = $urandom; ee1 = $urandom;
    te0 = $urandom & ~32'(ev_bit(j)); te1 = $urandom | 32'(ev_bit(k - 32));
    ej = {ee1, ee0} & ev_bit(j); ek = {ee1, ee0} & ev_bit(k);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h60, 32'h0);
    rchk(8'h64, 32'h0);
    acc(1'b1, 8'h00, ee0); acc(1'b1, 8'h20, te0);
    acc(1'b1, 8'h60, 32'hFF);
    rchk(8'h60, 32'h1);
    `CHK(rd2, 32'h0);
    acc(1'b1, 8'h00, ee1); acc(1'b1, 8'h20, te1);
    rchk(8'h00, ee1);
    rchk(8'h20, te1);
    acc(1'b1, 8'h60, 32'h0);
    rchk(8'h00, ee0);
    rchk(8'h20, te0);
    // Unmapped place answers with an error and reads zero
    acc(1'b1, 8'h04, 32'hFFFFFFFF);
    `CHK(rs, HEBTC_SLVERR);
    acc(1'b0, 8'h04, '0);
    `CHK({rs, rd}, {HEBTC_SLVERR, 32'h0});
    global_trace_en_i <= 1'b1;
    pulse(j, 64'h0, 0, 0);
    acc(1'b1, 8'h64, 32'h81);
    global_trace_en_i <= 1'b0;
    pulse(k, 64'h0, 0, 0);
    global_trace_en_i <= 1'b1;
    pulse(k, ek, 1, 1);
    pulse(k, ek, 1, 1);
    pulse(j, ej, 0, 0);
    acc(1'b1, 8'h64, 32'h01);
    pulse(k, ek, 1, 0);
    acc(1'b1, 8'h64, 32'h91);
    rchk(8'h64, 32'h91);
    `CHK(rd2, 32'h11);
    pulse(k, ek, 1, 1);
    rchk(8'h64, 32'hB1);
    pulse(k, ek, 0, 0);
    acc(1'b1, 8'h64, 32'h91);
    rchk(8'h64, 32'hB1);
    acc(1'b1, 8'h64, 32'hD1);
    rchk(8'h64, 32'h91);
    pulse(k, ek, 1, 1);
    `CHK(trigger_atid_o, 7'h7D);
    stop_test();
  end
endmodule : tb_top
